// ---- design/ipc_cfg.svh ----
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH

// ************************************************************
// register byte offsets on the register bus
// ************************************************************
`define IPC_OFS_EXT_INT_3_4       12'h000
`define IPC_OFS_RTC               12'h004
`define IPC_OFS_CRC_UART_ERR_A    12'h008
`define IPC_OFS_LOW_VOLTAGE       12'h00C
`define IPC_OFS_CHARGE_TIMER      12'h010
`define IPC_OFS_UART_THIRD        12'h014
`define IPC_OFS_USB_I2C_THIRD     12'h018
`define IPC_OFS_SPI_UART_FOURTH   12'h01C

// ************************************************************
// field positions inside a 16-bit priority word
// ************************************************************
`define IPC_F0_LSB                0
`define IPC_F1_LSB                4
`define IPC_F2_LSB                8
`define IPC_F3_LSB                12

// ************************************************************
// implemented bits per register (three per priority field)
// ************************************************************
`define IPC_MASK_EXT_INT_3_4      16'h0770
`define IPC_MASK_RTC              16'h0700
`define IPC_MASK_CRC_UART_ERR_A   16'h7770
`define IPC_MASK_LOW_VOLTAGE      16'h0007
`define IPC_MASK_CHARGE_TIMER     16'h0070
`define IPC_MASK_UART_THIRD       16'h7770
`define IPC_MASK_USB_I2C_THIRD    16'h7777
`define IPC_MASK_SPI_UART_FOURTH  16'h7777

// ************************************************************
// reset values and level codes
// ************************************************************
`define IPC_RST_PATTERN           16'h4444
`define IPC_LEVEL_OFF             3'h0
`define IPC_LEVEL_MAX             3'h7

// ************************************************************
// bus answers
// ************************************************************
`define IPC_RESP_OKAY             2'h0
`define IPC_RESP_SLVERR           2'h2

`endif

// ---- design/ipc_pkg.sv ----
`default_nettype none
package ipc_pkg;

	// ************************************************************
	// shared types
	// ************************************************************
	typedef logic [2:0] ipc_level_type;	// one priority field

	// per-source levels, highest source index first
	typedef struct packed {
		ipc_level_type sync_serial3_event_level;
		ipc_level_type sync_serial3_fault_level;
		ipc_level_type serial4_tx_level;
		ipc_level_type serial4_rx_level;
		ipc_level_type serial4_err_level;
		ipc_level_type usb_port_level;
		ipc_level_type twowire3_master_level;
		ipc_level_type twowire3_slave_level;
		ipc_level_type serial3_tx_level;
		ipc_level_type serial3_rx_level;
		ipc_level_type serial3_err_level;
		ipc_level_type charge_timer_level;
		ipc_level_type brownout_warn_level;
		ipc_level_type checksum_err_level;
		ipc_level_type serial2_err_level;
		ipc_level_type serial1_err_level;
		ipc_level_type calendar_level;
		ipc_level_type ext_irq4_level;
		ipc_level_type ext_irq3_level;
	} ipc_levels_type;

	// master to slave signals of the register bus
	typedef struct packed {
		logic        awvalid;
		logic [11:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [11:0] araddr;
		logic        rready;
	} ipc_axi_req_type;

	// slave to master signals of the register bus
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ipc_axi_rsp_type;

	// bus channel states, gray coded
	typedef enum logic [1:0] {
		IPC_ST_IDLE = 2'h0,
		IPC_ST_BUSY = 2'h1
	} ipc_bus_state_type;

endpackage
`default_nettype wire

// ---- design/ipc_prio_word.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ipc_cfg.svh"

module ipc_prio_word #(
	parameter logic [15:0] MASK_P = 16'h0000	// implemented bits
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic [1:0]  wr_be,
	output var  logic [15:0] word_q
);
	import ipc_pkg::*;

	logic [15:0] word_d;	// next word value

	// ************************************************************
	// byte-lane write, holes forced to zero
	// ************************************************************
	always_comb begin
		word_d = word_q;
		if (wr_en) begin
			if (wr_be[0]) begin
				word_d[7:0] = wr_data[7:0];	// RQ6
			end
			if (wr_be[1]) begin
				word_d[15:8] = wr_data[15:8];	// RQ6
			end
		end
		word_d = word_d & MASK_P;	// RQ10 RQ4 RQ7
	end

	// each field wakes at level four
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			word_q <= `IPC_RST_PATTERN & MASK_P;	// RQ5 RQ9
		end else begin
			word_q <= word_d;
		end
	end

endmodule // ipc_prio_word
`default_nettype wire

// ---- design/ipc_prio_regs.sv ----
// Summary of operation
// RQ1: three-bit field, codes one-seven give levels
// RQ2: all ones means level seven, highest
// RQ3: zero field disables its source entirely
// RQ4: bits without a field read zero
// RQ5: reset loads each field as binary 100
// RQ6: software reads and writes every field
// RQ7: fields only at 14-12, 10-8, 6-4, 2-0
// RQ8: separate field for each listed source
// RQ9: every source at level four after reset
// RQ10: writes to holes ignored, read zero
// RQ11: levels shown continuously, effective next cycle
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ipc_cfg.svh"

module ipc_prio_regs (
	input  wire logic                     mclk,
	input  wire logic                     resetn,
	input  wire ipc_pkg::ipc_axi_req_type axi_req,
	output var  ipc_pkg::ipc_axi_rsp_type axi_rsp,
	input  wire logic [18:0]              src_flag,
	output var  ipc_pkg::ipc_levels_type  levels,
	output var  logic [18:0]              src_req_q,
	output var  logic [2:0]               top_level_q
);
	import ipc_pkg::*;

	// ************************************************************
	// register map tables
	// ************************************************************
	localparam int NREG = 8;	// priority words
	localparam int NSRC = 19;	// interrupt sources

	// byte offset of each word, bank order
	localparam logic [NREG-1:0][11:0] OFS_TAB = {
		`IPC_OFS_SPI_UART_FOURTH, `IPC_OFS_USB_I2C_THIRD, `IPC_OFS_UART_THIRD,
		`IPC_OFS_CHARGE_TIMER, `IPC_OFS_LOW_VOLTAGE, `IPC_OFS_CRC_UART_ERR_A,
		`IPC_OFS_RTC, `IPC_OFS_EXT_INT_3_4};
	// implemented bits of each word, bank order
	localparam logic [NREG-1:0][15:0] MASK_TAB = {
		`IPC_MASK_SPI_UART_FOURTH, `IPC_MASK_USB_I2C_THIRD, `IPC_MASK_UART_THIRD,
		`IPC_MASK_CHARGE_TIMER, `IPC_MASK_LOW_VOLTAGE, `IPC_MASK_CRC_UART_ERR_A,
		`IPC_MASK_RTC, `IPC_MASK_EXT_INT_3_4};

	// ************************************************************
	// declarations
	// ************************************************************
	logic [NREG-1:0][15:0] bank_word;	// stored words
	logic [NREG-1:0]       bank_we;		// one-hot write pulse
	logic [15:0]           bank_wdata;	// write data to bank
	logic [1:0]            bank_be;		// write lanes to bank

	ipc_bus_state_type     wst_q, wst_d;	// write channel state
	logic                  aw_full_q, aw_full_d;	// address held
	logic                  w_full_q, w_full_d;	// data held
	logic [11:0]           awaddr_q, awaddr_d;	// held address
	logic [31:0]           wdata_q, wdata_d;	// held data
	logic [3:0]            wstrb_q, wstrb_d;	// held strobes
	logic                  awready_q, awready_d;
	logic                  wready_q, wready_d;
	logic                  bvalid_q, bvalid_d;
	logic [1:0]            bresp_q, bresp_d;

	ipc_bus_state_type     rst_q, rst_d;	// read channel state
	logic                  arready_q, arready_d;
	logic                  rvalid_q, rvalid_d;
	logic [31:0]           rdata_q, rdata_d;
	logic [1:0]            rresp_q, rresp_d;

	logic [NSRC-1:0][2:0]  lvl_arr;		// levels by source index
	logic [NSRC-1:0]       src_req_d;	// gated requests
	logic [2:0]            top_level_d;	// highest live level

	// ************************************************************
	// address decode
	// ************************************************************
	// one-hot hit of an address against the word table
	function automatic logic [NREG-1:0] decode(input logic [11:0] addr);
		logic [NREG-1:0] hit;
		hit = '0;
		for (int i = 0; i < NREG; i++) begin
			hit[i] = ({addr[11:2], 2'h0} == OFS_TAB[i]);
		end
		return hit;
	endfunction

	// ************************************************************
	// priority word bank
	// ************************************************************
	generate
		for (genvar g = 0; g < NREG; g++) begin : g_word
			// one stored word per register
			ipc_prio_word #(
				.MASK_P (MASK_TAB[g])
			) u_word (
				.mclk    (mclk),
				.resetn  (resetn),
				.wr_en   (bank_we[g]),
				.wr_data (bank_wdata),
				.wr_be   (bank_be),
				.word_q  (bank_word[g])
			);
		end
	endgenerate

	// ************************************************************
	// write channel
	// ************************************************************
	// take address and data in any order, write once both are in
	always_comb begin
		logic            aw_fire;
		logic            w_fire;
		logic [11:0]     addr_use;
		logic [NREG-1:0] hit;
		aw_fire    = axi_req.awvalid & awready_q;
		w_fire     = axi_req.wvalid & wready_q;
		addr_use   = aw_fire ? axi_req.awaddr : awaddr_q;
		hit        = decode(addr_use);
		wst_d      = wst_q;
		aw_full_d  = aw_full_q;
		w_full_d   = w_full_q;
		awaddr_d   = awaddr_q;
		wdata_d    = wdata_q;
		wstrb_d    = wstrb_q;
		bvalid_d   = bvalid_q;
		bresp_d    = bresp_q;
		bank_we    = '0;
		bank_wdata = w_fire ? axi_req.wdata[15:0] : wdata_q[15:0];
		bank_be    = w_fire ? axi_req.wstrb[1:0] : wstrb_q[1:0];
		case (wst_q)
			IPC_ST_IDLE: begin
				// capture whichever half arrives
				if (aw_fire) begin
					aw_full_d = 1'b1;
					awaddr_d  = axi_req.awaddr;
				end
				if (w_fire) begin
					w_full_d = 1'b1;
					wdata_d  = axi_req.wdata;
					wstrb_d  = axi_req.wstrb;
				end
				// both halves present: commit and answer
				if ((aw_full_q | aw_fire) && (w_full_q | w_fire)) begin
					bank_we   = hit;	// RQ6
					bresp_d   = (|hit) ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
					bvalid_d  = 1'b1;
					aw_full_d = 1'b0;
					w_full_d  = 1'b0;
					wst_d     = IPC_ST_BUSY;
				end
			end
			IPC_ST_BUSY: begin
				// hold the answer until the master takes it
				if (axi_req.bready) begin
					bvalid_d = 1'b0;
					wst_d    = IPC_ST_IDLE;
				end
			end
			default: begin
				// stray code, go back to idle
				bvalid_d  = 1'b0;
				aw_full_d = 1'b0;
				w_full_d  = 1'b0;
				wst_d     = IPC_ST_IDLE;
			end
		endcase
		awready_d = (wst_d == IPC_ST_IDLE) & ~aw_full_d;
		wready_d  = (wst_d == IPC_ST_IDLE) & ~w_full_d;
	end

	// write channel registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wst_q     <= IPC_ST_IDLE;
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			bvalid_q  <= 1'b0;
			bresp_q   <= `IPC_RESP_OKAY;
		end else begin
			wst_q     <= wst_d;
			aw_full_q <= aw_full_d;
			w_full_q  <= w_full_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
		end
	end

	// ************************************************************
	// read channel
	// ************************************************************
	// one read at a time, data captured at address take
	always_comb begin
		logic            ar_fire;
		logic [NREG-1:0] hit;
		logic [15:0]     word;
		ar_fire   = axi_req.arvalid & arready_q;
		hit       = decode(axi_req.araddr);
		word      = 16'h0000;
		rst_d     = rst_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		for (int i = 0; i < NREG; i++) begin
			if (hit[i]) begin
				word = bank_word[i];	// RQ6 RQ4
			end
		end
		case (rst_q)
			IPC_ST_IDLE: begin
				// upper half always zero
				if (ar_fire) begin
					rdata_d   = {16'h0000, word};	// RQ4
					rresp_d   = (|hit) ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
					rvalid_d  = 1'b1;
					arready_d = 1'b0;
					rst_d     = IPC_ST_BUSY;
				end
			end
			IPC_ST_BUSY: begin
				// data stands until taken
				if (axi_req.rready) begin
					rvalid_d  = 1'b0;
					arready_d = 1'b1;
					rst_d     = IPC_ST_IDLE;
				end
			end
			default: begin
				// stray code, go back to idle
				rvalid_d  = 1'b0;
				arready_d = 1'b1;
				rst_d     = IPC_ST_IDLE;
			end
		endcase
	end

	// read channel registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_q     <= IPC_ST_IDLE;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `IPC_RESP_OKAY;
		end else begin
			rst_q     <= rst_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// bus outputs, all from flip-flops
	always_comb begin
		axi_rsp.awready = awready_q;
		axi_rsp.wready  = wready_q;
		axi_rsp.bvalid  = bvalid_q;
		axi_rsp.bresp   = bresp_q;
		axi_rsp.arready = arready_q;
		axi_rsp.rvalid  = rvalid_q;
		axi_rsp.rdata   = rdata_q;
		axi_rsp.rresp   = rresp_q;
	end

	// ************************************************************
	// per-source level outputs
	// ************************************************************
	// stored fields straight out to the arbiter
	always_comb begin
		levels.ext_irq3_level           = bank_word[0][`IPC_F1_LSB +: 3];	// RQ8
		levels.ext_irq4_level           = bank_word[0][`IPC_F2_LSB +: 3];	// RQ8
		levels.calendar_level           = bank_word[1][`IPC_F2_LSB +: 3];	// RQ8
		levels.serial1_err_level        = bank_word[2][`IPC_F1_LSB +: 3];	// RQ8
		levels.serial2_err_level        = bank_word[2][`IPC_F2_LSB +: 3];	// RQ8
		levels.checksum_err_level       = bank_word[2][`IPC_F3_LSB +: 3];	// RQ8
		levels.brownout_warn_level      = bank_word[3][`IPC_F0_LSB +: 3];	// RQ8
		levels.charge_timer_level       = bank_word[4][`IPC_F1_LSB +: 3];	// RQ8
		levels.serial3_err_level        = bank_word[5][`IPC_F1_LSB +: 3];	// RQ8
		levels.serial3_rx_level         = bank_word[5][`IPC_F2_LSB +: 3];	// RQ8
		levels.serial3_tx_level         = bank_word[5][`IPC_F3_LSB +: 3];	// RQ8
		levels.twowire3_slave_level     = bank_word[6][`IPC_F0_LSB +: 3];	// RQ8
		levels.twowire3_master_level    = bank_word[6][`IPC_F1_LSB +: 3];	// RQ8
		levels.usb_port_level           = bank_word[6][`IPC_F2_LSB +: 3];	// RQ8
		levels.serial4_err_level        = bank_word[6][`IPC_F3_LSB +: 3];	// RQ8
		levels.serial4_rx_level         = bank_word[7][`IPC_F0_LSB +: 3];	// RQ8
		levels.serial4_tx_level         = bank_word[7][`IPC_F1_LSB +: 3];	// RQ8
		levels.sync_serial3_fault_level = bank_word[7][`IPC_F2_LSB +: 3];	// RQ8
		levels.sync_serial3_event_level = bank_word[7][`IPC_F3_LSB +: 3];	// RQ11
	end

	// same fields indexed by source number
	assign lvl_arr = levels;

	// ************************************************************
	// request gating and top level
	// ************************************************************
	// a zero field blocks the flag, others pass
	generate
		for (genvar s = 0; s < NSRC; s++) begin : g_req
			assign src_req_d[s] = src_flag[s] & (lvl_arr[s] != `IPC_LEVEL_OFF);	// RQ3
		end
	endgenerate

	// largest level among live requests, seven is highest
	always_comb begin
		top_level_d = `IPC_LEVEL_OFF;
		for (int i = 0; i < NSRC; i++) begin
			if (src_req_d[i] && (lvl_arr[i] > top_level_d)) begin
				top_level_d = lvl_arr[i];	// RQ1 RQ2
			end
		end
	end

	// request outputs registered
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			src_req_q   <= '0;
			top_level_q <= `IPC_LEVEL_OFF;
		end else begin
			src_req_q   <= src_req_d;	// RQ11
			top_level_q <= top_level_d;
		end
	end

endmodule // ipc_prio_regs
`default_nettype wire

// ---- bench/ipc_prio_regs_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module ipc_prio_regs_chk (
	input wire logic                     mclk,
	input wire logic                     resetn,
	input wire ipc_pkg::ipc_axi_req_type axi_req,
	input wire ipc_pkg::ipc_axi_rsp_type axi_rsp,
	input wire logic [18:0]              src_flag,
	input wire ipc_pkg::ipc_levels_type  levels,
	input wire logic [18:0]              src_req_q,
	input wire logic [2:0]               top_level_q
);
	import ipc_pkg::*;
	// ****
	// helpers
	// ****
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// flags gated by a nonzero level
	function automatic logic [18:0] gate_f(logic [18:0] f, logic [56:0] l);
		for (int i = 0; i < 19; i++) gate_f[i] = f[i] && (l[3*i+:3] != 3'h0);
	endfunction
	// highest level among flagged sources
	function automatic logic [2:0] top_f(logic [18:0] f, logic [56:0] l);
		top_f = 3'h0;
		for (int i = 0; i < 19; i++) if (f[i] && l[3*i+:3] > top_f) top_f = l[3*i+:3];
	endfunction
	// ****
	// assertions
	// ****
	gate_req_a: assert property ($past(resetn) |->
		src_req_q == gate_f($past(src_flag), $past(levels))) else $error("gated request wrong");
	top_lvl_a: assert property ($past(resetn) |->
		top_level_q == top_f($past(src_flag), $past(levels))) else $error("top level wrong");
	reset_lvl_a: assert property ($rose(resetn) |-> levels == {19{3'h4}})
		else $error("levels not four after reset");
	lvl_hold_a: assert property ($changed(levels) |-> $rose(axi_rsp.bvalid))
		else $error("levels moved without a write");
	wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready &&
		axi_req.wvalid && axi_rsp.wready |=> axi_rsp.bvalid) else $error("no write answer");
	rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
		else $error("no read answer");
	hole_zero_a: assert property (axi_rsp.rvalid |-> (axi_rsp.rdata & 32'hFFFF8888) == 0)
		else $error("hole bits read nonzero");
	b_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=>
		!axi_rsp.bvalid && axi_rsp.awready) else $error("write answer not closed");
	r_done_a: assert property (axi_rsp.rvalid && axi_req.rready |=>
		!axi_rsp.rvalid && axi_rsp.arready) else $error("read answer not closed");
	busy_refuse_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken while busy");
endmodule // ipc_prio_regs_chk
`default_nettype wire

// ---- bench/ipc_prio_regs_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ipc_cfg.svh"
module ipc_prio_regs_test;
	import ipc_pkg::*;
	// ****
	// signals and model
	// ****
	logic            mclk;
	logic            resetn;
	ipc_axi_req_type req;
	ipc_axi_rsp_type rsp;
	logic [18:0]     src_flag;
	ipc_levels_type  levels;
	logic [18:0]     src_req_q;
	logic [2:0]      top_level_q;
	logic [31:0]     seed = 32'h13CF6136;	// xorshift state
	logic [15:0]     exp_w [8];	// expected words
	int              mismatches = 0;
	int              n_compared = 0;
	// register and field position of each source
	int sr [19] = '{0, 0, 1, 2, 2, 2, 3, 4, 5, 5, 5, 6, 6, 6, 6, 7, 7, 7, 7};
	int sl [19] = '{4, 8, 8, 4, 8, 12, 0, 4, 4, 8, 12, 0, 4, 8, 12, 0, 4, 8, 12};
	logic [15:0] msk [8] = '{`IPC_MASK_EXT_INT_3_4, `IPC_MASK_RTC, `IPC_MASK_CRC_UART_ERR_A,
		`IPC_MASK_LOW_VOLTAGE, `IPC_MASK_CHARGE_TIMER, `IPC_MASK_UART_THIRD,
		`IPC_MASK_USB_I2C_THIRD, `IPC_MASK_SPI_UART_FOURTH};

	ipc_prio_regs u_dut (
		.mclk        (mclk),
		.resetn      (resetn),
		.axi_req     (req),
		.axi_rsp     (rsp),
		.src_flag    (src_flag),
		.levels      (levels),
		.src_req_q   (src_req_q),
		.top_level_q (top_level_q)
	);

	// free running clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// ****
	// helpers
	// ****
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected flat level vector
	function automatic logic [56:0] exp_lv();
		for (int i = 0; i < 19; i++) exp_lv[3*i+:3] = exp_w[sr[i]][sl[i]+:3];
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// one bus write, address and data offered together
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] be,
		input logic [1:0] er);
		logic [31:0] r;
		bit          got;
		r = rnd();
		got = 1'b0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {r[31:16], d};	// upper half ignored
		req.wstrb <= {r[1:0], be};
		// bready stays high between calls, so no call re-raises it in one step
		req.bready <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge mclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				got = 1'b1;
				chk(64'(rsp.bresp), 64'(er));
			end
		end
		if (!got) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// one bus read
	task automatic rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
		bit got;
		got = 1'b0;
		req.arvalid <= 1'b1;
		req.araddr <= a;
		// rready stays high between calls, like bready
		req.rready <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge mclk);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				got = 1'b1;
				chk(64'(rsp.rdata), 64'({16'h0, e}));
				chk(64'(rsp.rresp), 64'(er));
			end
		end
		if (!got) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// write a register, update model, check levels and readback
	task automatic wreg(input int r, input logic [15:0] d, input logic [1:0] be);
		logic [15:0] m;
		m = msk[r] & {{8{be[1]}}, {8{be[0]}}};
		wr(12'(r * 4), d, be, `IPC_RESP_OKAY);
		exp_w[r] = (exp_w[r] & ~m) | (d & m);
		chk(64'(levels), 64'(exp_lv()));
		rd(12'(r * 4), exp_w[r], `IPC_RESP_OKAY);
	endtask
	// drive flags, check gated requests and top level
	task automatic flags(input logic [18:0] f);
		logic [56:0] l;
		logic [18:0] g;
		logic [2:0]  t;
		@(posedge mclk);
		src_flag <= f;
		@(posedge mclk);
		// one edge to register, compare before the next update
		@(posedge mclk);
		l = exp_lv();
		t = 3'h0;
		for (int i = 0; i < 19; i++) begin
			g[i] = f[i] && l[3*i+:3] != 3'h0;
			if (g[i] && l[3*i+:3] > t) t = l[3*i+:3];
		end
		chk(64'(src_req_q), 64'(g));
		chk(64'(top_level_q), 64'(t));
	endtask
	// reset values of all words
	task automatic rst_chk();
		for (int r = 0; r < 8; r++) exp_w[r] = msk[r] & `IPC_RST_PATTERN;
		chk(64'(levels), 64'(exp_lv()));
		for (int r = 0; r < 8; r++) rd(12'(r * 4), exp_w[r], `IPC_RESP_OKAY);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		req = '0;
		src_flag = '0;
		resetn = 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rst_chk();
		flags('1);
		// unmapped place refused, nothing moves
		wr(12'h020, 16'hFFFF, 2'b11, `IPC_RESP_SLVERR);
		rd(12'hFFC, 16'h0, `IPC_RESP_SLVERR);
		chk(64'(levels), 64'(exp_lv()));
		// every code in every field
		for (int c = 0; c < 8; c++) begin
			for (int r = 0; r < 8; r++) wreg(r, {4{1'b1, 3'(c)}}, 2'b11);
			flags('1);
		end
		// random words, lanes and flags
		for (int k = 0; k < 120; k++) begin
			wreg(int'(rnd() & 7), 16'(rnd()), 2'(rnd()));
			flags(19'(rnd()));
		end
		// reset in mid run
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		rst_chk();
		flags(19'(rnd()));
		wrap_up();
	end
endmodule // ipc_prio_regs_test

bind ipc_prio_regs ipc_prio_regs_chk u_chk (
	.mclk        (mclk),
	.resetn      (resetn),
	.axi_req     (axi_req),
	.axi_rsp     (axi_rsp),
	.src_flag    (src_flag),
	.levels      (levels),
	.src_req_q   (src_req_q),
	.top_level_q (top_level_q)
);
`default_nettype wire
